/* lvh_top.sv */
`timescale 1ns/1ps
module lvh_top
  import lvh_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // probe pins, high when wetted
  input  wire logic lowest_probe,
  input  wire logic second_probe,
  input  wire logic third_probe,
  input  wire logic top_probe,
  // jumpers, high inverts the channel relay
  input  wire logic fill_invert,
  input  wire logic drain_invert,
  // relay drives
  output logic      fill_relay,
  output logic      drain_relay,
  // lamps
  output logic      fill_lamp_first,
  output logic      fill_lamp_second,
  output logic      fill_lamp_third,
  output logic      fill_lamp_fourth,
  output logic      empty_lamp
);
  // probe levels: raw pins, filtered, and one cycle older
  logic [NUM_PRB-1:0]  raw;
  logic [NUM_PRB-1:0]  wet;
  logic [NUM_PRB-1:0]  wet_q;
  logic [NUM_PRB-1:0]  next_wet_q;
  // jumper synchronisers
  logic [1:0]          inv_sync0;
  logic [1:0]          inv_sync1;
  logic [1:0]          next_inv_sync0;
  logic [1:0]          next_inv_sync1;
  // start-up control
  lvh_state_t          state;
  lvh_state_t          next_state;
  logic [SETTLE_W-1:0] settle_cnt;
  logic [SETTLE_W-1:0] next_settle_cnt;
  logic                seeding;
  // filling channel
  logic                fill_on;
  logic                next_fill_on;
  logic                next_fill_relay;
  // draining channel
  logic                drain_on;
  logic                next_drain_on;
  logic                next_drain_relay;
  // lamps
  logic [NUM_PRB-1:0]  next_lamps;
  logic                next_empty;

  // pins gathered in probe order, lowest first
  assign raw = {top_probe, third_probe, second_probe, lowest_probe};

  genvar gi;
  generate
    for (gi = 0; gi < NUM_PRB; gi = gi + 1) begin : g_prb
      lvh_debounce u_deb (
        .clk   (clk),
        .rst_n (rst_n),
        .raw   (raw[gi]),
        .level (wet[gi])
      );
    end
  endgenerate

  // true when a filtered probe has just gone from wetted to dry
  function automatic logic dried(input logic was_wet, input logic is_wet);
    return was_wet && !is_wet;
  endfunction : dried

  // jumper synchronisers: two flops before the relays read them
  always_comb begin
    next_inv_sync0 = {inv_sync0[0], fill_invert};
    next_inv_sync1 = {inv_sync1[0], drain_invert};
  end

  // jumper registers; first stage read only by the second
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      inv_sync0 <= SYNC_RST;
      inv_sync1 <= SYNC_RST;
    end else begin
      inv_sync0 <= next_inv_sync0;
      inv_sync1 <= next_inv_sync1;
    end
  end

  // seed window while the probe filters settle
  always_comb begin
    next_state      = state;
    next_settle_cnt = settle_cnt;
    case (state)
      LVH_INIT: begin
        if (settle_cnt == SETTLE_W'(SETTLE_CYCLES - 1)) begin
          next_state = LVH_RUN;
        end else begin
          next_settle_cnt = settle_cnt + SETTLE_W'(1);
        end
      end
      LVH_RUN: begin
        next_state = LVH_RUN;
      end
      default: begin
        next_state = LVH_INIT;
      end
    endcase
  end

  // relays follow probe levels while seeding, react to events afterwards
  assign seeding = (state == LVH_INIT);

  // start-up registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      state      <= LVH_INIT;
      settle_cnt <= SETTLE_RST;
    end else begin
      state      <= next_state;
      settle_cnt <= next_settle_cnt;
    end
  end

  // previous filtered levels, for the wet-to-dry events
  always_comb begin
    next_wet_q = wet;
  end

  // level history register
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      wet_q <= WET_RST;
    end else begin
      wet_q <= next_wet_q;
    end
  end

  // filling channel: reads only the lowest and second probes
  always_comb begin
    next_fill_on = fill_on;
    if (seeding) begin
      next_fill_on = !wet[PRB_LOW];
    end else begin
      if (dried(wet_q[PRB_LOW], wet[PRB_LOW])) begin
        next_fill_on = 1'b1;
      end
      if (wet[PRB_SECOND]) begin
        next_fill_on = 1'b0;
      end
    end
    next_fill_relay = next_fill_on ^ inv_sync0[1];
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fill_on    <= 1'b0;
      fill_relay <= 1'b0;
    end else begin
      fill_on    <= next_fill_on;
      fill_relay <= next_fill_relay;
    end
  end

  // draining channel: reads only the third and top probes
  always_comb begin
    next_drain_on = drain_on;
    if (seeding) begin
      next_drain_on = wet[PRB_TOP];
    end else if (wet[PRB_TOP]) begin
      next_drain_on = 1'b1;
    end else if (dried(wet_q[PRB_THIRD], wet[PRB_THIRD])) begin
      next_drain_on = 1'b0;
    end
    next_drain_relay = next_drain_on ^ inv_sync1[1];
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      drain_on    <= 1'b0;
      drain_relay <= 1'b0;
    end else begin
      drain_on    <= next_drain_on;
      drain_relay <= next_drain_relay;
    end
  end

  // lamps: one per probe and one for an empty reservoir
  always_comb begin
    next_lamps = wet;
    next_empty = (wet == WET_RST);
  end

  // lamp registers
  always_ff @(posedge clk) begin
    if (!rst_n) begin
      fill_lamp_first  <= 1'b0;
      fill_lamp_second <= 1'b0;
      fill_lamp_third  <= 1'b0;
      fill_lamp_fourth <= 1'b0;
      empty_lamp       <= 1'b0;
    end else begin
      fill_lamp_first  <= next_lamps[PRB_LOW];
      fill_lamp_second <= next_lamps[PRB_SECOND];
      fill_lamp_third  <= next_lamps[PRB_THIRD];
      fill_lamp_fourth <= next_lamps[PRB_TOP];
      empty_lamp       <= next_empty;
    end
  end
endmodule : lvh_top

/* lvh_pkg.sv */
package lvh_pkg;
  // debounce: samples must agree this many consecutive times
  localparam int unsigned DEB_COUNT   = 16;
  localparam int unsigned DEB_W       = 5;
  // probe indices
  localparam int unsigned PRB_LOW     = 0;
  localparam int unsigned PRB_SECOND  = 1;
  localparam int unsigned PRB_THIRD   = 2;
  localparam int unsigned PRB_TOP     = 3;
  localparam int unsigned NUM_PRB     = 4;
  // reset values
  localparam logic [DEB_W-1:0] DEB_RST = 5'h00;
  localparam logic [1:0]      SYNC_RST = 2'h0;
  localparam logic [NUM_PRB-1:0] WET_RST = 4'h0;
  // start-up: relays reseed from probes until the filters have settled
  localparam int unsigned SETTLE_CYCLES = DEB_COUNT + 4;
  localparam int unsigned SETTLE_W      = 5;
  localparam logic [SETTLE_W-1:0] SETTLE_RST = 5'h00;
  // channel control states
  typedef enum logic [1:0] {
    LVH_INIT = 2'b00,
    LVH_RUN  = 2'b01
  } lvh_state_t;
endpackage : lvh_pkg

/* lvh_debounce.sv */
`timescale 1ns/1ps
module lvh_debounce
  import lvh_pkg::*;
(
  // clock and reset
  input  wire logic clk,
  input  wire logic rst_n,
  // raw pin and filtered level
  input  wire logic raw,
  output logic      level
);
  logic [1:0]       sync;
  logic [DEB_W-1:0] cnt;
  logic [DEB_W-1:0] next_cnt;
  logic             next_level;

  // count samples that differ from level, flip level after a full run
  always_comb begin
    next_cnt   = cnt;
    next_level = level;
    if (sync[1] == level) begin
      next_cnt = DEB_RST;
    end else if (cnt == DEB_W'(DEB_COUNT - 1)) begin
      next_cnt   = DEB_RST;
      next_level = sync[1];
    end else begin
      next_cnt = cnt + DEB_W'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync  <= SYNC_RST;
      cnt   <= DEB_RST;
      level <= 1'b0;
    end else begin
      sync  <= {sync[0], raw};  // first stage read only by second
      cnt   <= next_cnt;
      level <= next_level;
    end
  end
endmodule : lvh_debounce

/* lvh_monitor.sv */
`timescale 1ns/1ps
module lvh_monitor (
  // top module ports
  input wire logic clk, rst_n, lowest_probe, fill_invert, drain_invert, fill_relay, drain_relay,
  input wire logic empty_lamp, fill_lamp_first, fill_lamp_second, fill_lamp_third, fill_lamp_fourth
);
  logic [4:0] rc;
  logic [3:0] fh, dh;
  wire  [3:0] lp = {fill_lamp_fourth, fill_lamp_third, fill_lamp_second, fill_lamp_first};
  wire        fok = rc == 5'h18 && fh == {4{fill_invert}};
  wire        dok = rc == 5'h18 && dh == {4{drain_invert}};
  // age since reset and jumper history, so relays are judged only once settled
  // (relays reseed from the probes while the filters settle after reset)
  always_ff @(posedge clk) begin
    rc <= !rst_n ? 5'h00 : rc + 5'(rc != 5'h18);
    fh <= {fh[2:0], fill_invert};
    dh <= {dh[2:0], drain_invert};
  end
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  a_empty_lamp: assert property (
    rc != 5'h00 |-> empty_lamp == (lp == 4'h0)) else $error("empty lamp");
  a_fill_off: assert property (
    fok && lp[1] |-> fill_relay == fill_invert) else $error("fill off");
  a_fill_on: assert property (
    fok && lp[1:0] == 2'h0 |-> fill_relay != fill_invert) else $error("fill on");
  a_fill_hold: assert property (
    fok && lp[1:0] == 2'h1 |-> $stable(fill_relay)) else $error("fill hold");
  a_drain_on: assert property (
    dok && lp[3] |-> drain_relay != drain_invert) else $error("drain on");
  a_drain_off: assert property (
    dok && lp[3:2] == 2'h0 |-> drain_relay == drain_invert) else $error("drain off");
  a_drain_hold: assert property (
    dok && lp[3:2] == 2'h1 |-> $stable(drain_relay)) else $error("drain hold");
  a_lamp_filter: assert property (
    $rose(lp[0]) |-> $past(lowest_probe, 5) && $past(lowest_probe, 15)) else $error("lamp filter");
  // main scenarios
  cover property (lp[3] && drain_relay);
  cover property ($rose(fill_relay));
  cover property ($fell(drain_relay));
endmodule : lvh_monitor

/* lvh_tank.sv */
`timescale 1ns/1ps
module lvh_tank (
  // water height 0 to 4 and a disturbance on the lowest probe
  input  wire logic [2:0] height,
  input  wire logic       glitch,
  // probes, high when wetted
  output logic      [3:0] probe
);
  // probes below the surface are wetted
  assign probe = 4'((5'h01 << height) - 5'h01) ^ {3'h0, glitch};
endmodule : lvh_tank

/* tb_two_channel_level_hysteresis.sv */
`timescale 1ns/1ps
module tb_two_channel_level_hysteresis;
  logic clk = 1'b0, rst_n = 1'b0, fill_invert = 1'b0, drain_invert = 1'b0, glitch = 1'b0;
  logic fs = 1'b1, ds = 1'b0;
  logic [2:0] h = 3'h0;
  logic [31:0] rnd = 32'hB008EDD4;
  logic [2:0] walk [10] = '{3'h1, 3'h2, 3'h3, 3'h4, 3'h3, 3'h2, 3'h1, 3'h0, 3'h1, 3'h2};
  int err_total = 0, comparisons = 0;
  wire lowest_probe, second_probe, third_probe, top_probe, fill_relay, drain_relay;
  wire empty_lamp, fill_lamp_first, fill_lamp_second, fill_lamp_third, fill_lamp_fourth;
  wire [4:0] lamps = {empty_lamp, fill_lamp_fourth, fill_lamp_third, fill_lamp_second, fill_lamp_first};
  lvh_tank u_tank (.height(h), .glitch(glitch), .probe({top_probe, third_probe, second_probe, lowest_probe}));
  lvh_top u_dut (.*);
  // clock and watchdog
  initial forever #2 clk = ~clk;
  initial begin
    #20000;
    err_total++;
    complete_run();
  end
  function automatic logic [31:0] xs(input logic [31:0] s);
    s ^= s << 13;
    s ^= s >> 17;
    return s ^ (s << 5);
  endfunction : xs
  // expected lamps: thermometer of wetted probes, empty lamp on top
  function automatic logic [4:0] lamp_exp(input logic [2:0] n);
    return {n == 3'h0, 4'((5'h01 << n) - 5'h01)};
  endfunction : lamp_exp
  // expected filling relay: on when empty, off once the second probe is wet
  function automatic logic fill_exp(input logic [2:0] n, input logic prev);
    return n > 3'h1 ? 1'b0 : (n == 3'h0 ? 1'b1 : prev);
  endfunction : fill_exp
  // expected draining relay: on when full, off once the third probe is dry
  function automatic logic drain_exp(input logic [2:0] n, input logic prev);
    return n == 3'h4 ? 1'b1 : (n < 3'h3 ? 1'b0 : prev);
  endfunction : drain_exp
  task automatic chk_lamps(input logic [4:0] got, input logic [4:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %0t lamps got %b exp %b", $time, got, exp);
    end
  endtask : chk_lamps
  task automatic chk_relays(input logic [1:0] got, input logic [1:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("mismatch %0t relays got %b exp %b", $time, got, exp);
    end
  endtask : chk_relays
  // reset mid-run with a level held; relays must seed from the probes
  task automatic restart(input logic [2:0] n);
    @(posedge clk);
    #1;
    rst_n = 1'b0;
    h = n;
    fill_invert = 1'b0;
    drain_invert = 1'b0;
    fs = n == 3'h0;
    ds = n == 3'h4;
    repeat (5) @(posedge clk);
    #1;
    rst_n = 1'b1;
  endtask : restart
  task automatic complete_run;
    $display("errors %0d comparisons %0d", err_total, comparisons);
    if (err_total == 0 && comparisons > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask : complete_run
  // move the level and jumpers, let filters settle, compare lamps and relays
  task automatic step(input logic [2:0] n, input logic f, input logic d);
    @(posedge clk);
    #1;
    h = n;
    fill_invert = f;
    drain_invert = d;
    fs = fill_exp(n, fs);
    ds = drain_exp(n, ds);
    repeat (25) @(posedge clk);
    #1;
    chk_lamps(lamps, lamp_exp(n));
    chk_relays({fill_relay, drain_relay}, {fs ^ f, ds ^ d});
  endtask : step
  // reset, hand walk, glitch, random walk
  initial begin
    repeat (5) @(posedge clk);
    #1;
    rst_n = 1'b1;
    step(3'h0, 1'b0, 1'b0);
    foreach (walk[i]) step(walk[i], 1'b0, 1'b0);
    glitch = 1'b1;
    repeat (8) @(posedge clk);
    #1;
    glitch = 1'b0;
    step(3'h2, 1'b0, 1'b0);
    repeat (40) begin
      rnd = xs(rnd);
      step(3'(rnd[2:0] % 3'h5), rnd[3], rnd[4]);
    end
    // resets with wetted probes: relays seed from the settled levels
    restart(3'h1);
    step(3'h1, 1'b0, 1'b0);
    restart(3'h4);
    step(3'h4, 1'b0, 1'b0);
    step(3'h3, 1'b0, 1'b0);
    step(3'h2, 1'b0, 1'b0);
    complete_run();
  end
endmodule : tb_two_channel_level_hysteresis
bind lvh_top lvh_monitor u_mon (.*);
